// ---- isf_defs.svh ----
`ifndef ISF_DEFS_SVH
`define ISF_DEFS_SVH

// register byte addresses
`define ISF_ADDR_CONTROL_ONE 8'h00
`define ISF_ADDR_DATA 8'h10
`define ISF_ADDR_STATUS_ONE 8'h14
`define ISF_ADDR_STATUS_TWO 8'h18
`define ISF_ADDR_W 8

// control_one fields
`define ISF_C1_ENABLE 0
`define ISF_C1_STRETCH_DIS 1
`define ISF_C1_CHECKSUM 2
`define ISF_C1_TEN_BIT 3

// event_status_one fields
`define ISF_S1_START 0
`define ISF_S1_ADDR 1
`define ISF_S1_BYTE_FIN 2
`define ISF_S1_TEN_HDR 3
`define ISF_S1_STOP 4
`define ISF_S1_RXNE 6
`define ISF_S1_TXE 7

// event_status_two fields
`define ISF_S2_MASTER 0
`define ISF_S2_TRANSMIT 2

// bus answers
`define ISF_RESP_OKAY 2'h0
`define ISF_RESP_SLVERR 2'h2
`define ISF_ZERO_WORD 32'h0000_0000
`define ISF_ZERO_BYTE 8'h00

`endif

// ---- isf_pkg.sv ----
package isf_pkg;

   // events from the protocol engine, same clock
   typedef struct packed {
      logic start_gen;
      logic stop_gen;
      logic addr_first_sent;
      logic addr_ack;
      logic addr_second;
      logic slave_match;
      logic ack_rcv;
      logic nack_rcv;
      logic byte_rcvd;
      logic tx_byte_taken;
      logic tx_due;
      logic addr_phase;
      logic master_mode;
      logic transmitter;
      logic [7:0] rx_byte;
   } isf_ev_t;

   typedef struct packed {
      logic start_sent_flag;
      logic address_done_flag;
      logic byte_finished_flag;
      logic ten_bit_header_sent_flag;
      logic stop_seen_flag;
      logic receive_not_empty_flag;
      logic transmit_empty_flag;
   } isf_flags_t;

   typedef struct packed {
      logic enable;
      logic stretch_disable;
      logic checksum_send_request;
      logic ten_bit_mode;
   } isf_ctrl_t;

   typedef struct packed {
      isf_flags_t flags;
      isf_ctrl_t ctrl;
      logic [7:0] tx_data;
      logic [7:0] rx_data;
      logic tx_load;
      logic status_armed;
      logic last_ack;
      logic scl_s1;
      logic scl_s2;
      logic scl_s3;
      logic sda_s1;
      logic sda_s2;
      logic sda_s3;
      logic awready;
      logic wready;
      logic aw_held;
      logic w_held;
      logic [7:0] awaddr;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } isf_state_t;

endpackage : isf_pkg

// ---- isf_event_flags.sv ----
`timescale 1ns/1ps
`include "isf_defs.svh"
// How it works
// - as slave, after an acknowledge, a seen stop condition sets stop flag.
// - no stop flag when the previous byte got a NACK.
// - status-one read then control-one write clears stop and ten-bit flags.
// - master ten-bit mode sets header flag after first byte, not on NACK.
// - stretching allowed, receive: new byte while data unread sets byte-finished.
// - stretching allowed, transmit: next byte due, data empty sets byte-finished.
// - no byte-finished after NACK or when next transmit byte is checksum.
// - status-one read then data read or write clears byte-finished.
// - in sending mode a generated start or stop clears byte-finished.
// - while byte-finished is set a data read keeps receive-not-empty set.
// - master sets address flag after 7-bit ack or second ten-bit byte ack.
// - slave sets address flag on address match.
// - status-one read then status-two read clears address flag.
// - master sets start flag once it has generated a start condition.
// - status-one read then data write clears start flag.
// - all five event flags forced low while peripheral enable is low.
// - receiving sets receive-not-empty on unread byte, not in address phase.
// - sending sets transmit-empty when data register empty, not in address phase.
module isf_event_flags
   import isf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   // axi4-lite slave
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // bus pins, sampled
   input wire logic scl_in,
   input wire logic sda_in,
   // protocol engine side
   input wire isf_ev_t ev,
   output isf_flags_t flags,
   output isf_ctrl_t ctrl,
   output logic [7:0] tx_data,
   output logic tx_load
);

   isf_state_t st_r;
   isf_state_t st_nxt;

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign s_axi_awready = st_r.awready;
   assign s_axi_wready = st_r.wready;
   assign s_axi_bresp = st_r.bresp;
   assign s_axi_bvalid = st_r.bvalid;
   assign s_axi_arready = st_r.arready;
   assign s_axi_rdata = st_r.rdata;
   assign s_axi_rresp = st_r.rresp;
   assign s_axi_rvalid = st_r.rvalid;
   assign flags = st_r.flags;
   assign ctrl = st_r.ctrl;
   assign tx_data = st_r.tx_data;
   assign tx_load = st_r.tx_load;

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      logic wr_go;
      logic rd_go;
      logic wr_c1;
      logic wr_dat;
      logic rd_s1;
      logic rd_s2;
      logic rd_dat;
      logic wr_map;
      logic rd_map;
      logic stop_det;
      logic any_acc;
      logic [31:0] rd_word;
      logic [7:0] wa;
      wr_go = 1'b0;
      rd_go = 1'b0;
      wr_c1 = 1'b0;
      wr_dat = 1'b0;
      rd_s1 = 1'b0;
      rd_s2 = 1'b0;
      rd_dat = 1'b0;
      wr_map = 1'b0;
      rd_map = 1'b1;
      stop_det = 1'b0;
      any_acc = 1'b0;
      rd_word = `ISF_ZERO_WORD;
      wa = st_r.awaddr;
      st_nxt = st_r;
      st_nxt.tx_load = 1'b0;

      // ----------------------------------------
      // pin synchronisers and stop detection
      // ----------------------------------------
      st_nxt.scl_s1 = scl_in;
      st_nxt.scl_s2 = st_r.scl_s1;
      st_nxt.scl_s3 = st_r.scl_s2;
      st_nxt.sda_s1 = sda_in;
      st_nxt.sda_s2 = st_r.sda_s1;
      st_nxt.sda_s3 = st_r.sda_s2;
      // sda rising while scl high
      stop_det = st_r.scl_s2 & st_r.scl_s3 & st_r.sda_s2 & ~st_r.sda_s3;

      // ----------------------------------------
      // axi write channel
      // ----------------------------------------
      if (s_axi_awvalid && st_r.awready) begin
         st_nxt.aw_held = 1'b1;
         st_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && st_r.wready) begin
         st_nxt.w_held = 1'b1;
         st_nxt.wdata = s_axi_wdata[7:0];
         st_nxt.wstrb0 = s_axi_wstrb[0];
      end
      if (st_r.bvalid && s_axi_bready) begin
         st_nxt.bvalid = 1'b0;
      end
      if (st_r.aw_held && st_r.w_held && !st_r.bvalid) begin
         wr_go = 1'b1;
         st_nxt.aw_held = 1'b0;
         st_nxt.w_held = 1'b0;
         st_nxt.bvalid = 1'b1;
      end
      if (wr_go) begin
         if (wa == `ISF_ADDR_CONTROL_ONE) begin
            wr_map = 1'b1;
            wr_c1 = 1'b1;
         end else if (wa == `ISF_ADDR_DATA) begin
            wr_map = 1'b1;
            wr_dat = st_r.wstrb0;
         end else if (wa == `ISF_ADDR_STATUS_ONE || wa == `ISF_ADDR_STATUS_TWO) begin
            wr_map = 1'b1;
         end
         st_nxt.bresp = wr_map ? `ISF_RESP_OKAY : `ISF_RESP_SLVERR;
      end
      if (wr_c1 && st_r.wstrb0) begin
         st_nxt.ctrl.enable = st_r.wdata[`ISF_C1_ENABLE];
         st_nxt.ctrl.stretch_disable = st_r.wdata[`ISF_C1_STRETCH_DIS];
         st_nxt.ctrl.checksum_send_request = st_r.wdata[`ISF_C1_CHECKSUM];
         st_nxt.ctrl.ten_bit_mode = st_r.wdata[`ISF_C1_TEN_BIT];
      end
      if (wr_dat) begin
         st_nxt.tx_data = st_r.wdata;
         st_nxt.tx_load = 1'b1;
      end
      st_nxt.awready = !st_nxt.aw_held && !st_nxt.bvalid;
      st_nxt.wready = !st_nxt.w_held && !st_nxt.bvalid;

      // ----------------------------------------
      // axi read channel
      // ----------------------------------------
      if (st_r.rvalid && s_axi_rready) begin
         st_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid && st_r.arready) begin
         rd_go = 1'b1;
         st_nxt.rvalid = 1'b1;
         if (s_axi_araddr == `ISF_ADDR_CONTROL_ONE) begin
            rd_word[`ISF_C1_ENABLE] = st_r.ctrl.enable;
            rd_word[`ISF_C1_STRETCH_DIS] = st_r.ctrl.stretch_disable;
            rd_word[`ISF_C1_CHECKSUM] = st_r.ctrl.checksum_send_request;
            rd_word[`ISF_C1_TEN_BIT] = st_r.ctrl.ten_bit_mode;
         end else if (s_axi_araddr == `ISF_ADDR_DATA) begin
            rd_word[7:0] = st_r.rx_data;
            rd_dat = 1'b1;
         end else if (s_axi_araddr == `ISF_ADDR_STATUS_ONE) begin
            rd_word[`ISF_S1_START] = st_r.flags.start_sent_flag;
            rd_word[`ISF_S1_ADDR] = st_r.flags.address_done_flag;
            rd_word[`ISF_S1_BYTE_FIN] = st_r.flags.byte_finished_flag;
            rd_word[`ISF_S1_TEN_HDR] = st_r.flags.ten_bit_header_sent_flag;
            rd_word[`ISF_S1_STOP] = st_r.flags.stop_seen_flag;
            rd_word[`ISF_S1_RXNE] = st_r.flags.receive_not_empty_flag;
            rd_word[`ISF_S1_TXE] = st_r.flags.transmit_empty_flag;
            rd_s1 = 1'b1;
         end else if (s_axi_araddr == `ISF_ADDR_STATUS_TWO) begin
            rd_word[`ISF_S2_MASTER] = ev.master_mode;
            rd_word[`ISF_S2_TRANSMIT] = ev.transmitter;
            rd_s2 = 1'b1;
         end else begin
            rd_map = 1'b0;
         end
         st_nxt.rdata = rd_word;
         st_nxt.rresp = rd_map ? `ISF_RESP_OKAY : `ISF_RESP_SLVERR;
      end
      st_nxt.arready = !st_nxt.rvalid;

      // ----------------------------------------
      // clear sequences
      // ----------------------------------------
      // a status-one read arms, the next other access consumes
      any_acc = wr_go | (rd_go & !rd_s1);
      if (rd_s1) begin
         st_nxt.status_armed = 1'b1;
      end else if (any_acc) begin
         st_nxt.status_armed = 1'b0;
      end
      if (st_r.status_armed) begin
         if (wr_c1) begin
            st_nxt.flags.stop_seen_flag = 1'b0;
            st_nxt.flags.ten_bit_header_sent_flag = 1'b0;
         end
         if (wr_dat || rd_dat) begin
            st_nxt.flags.byte_finished_flag = 1'b0;
         end
         if (rd_s2) begin
            st_nxt.flags.address_done_flag = 1'b0;
         end
         if (wr_dat) begin
            st_nxt.flags.start_sent_flag = 1'b0;
         end
      end
      // start or stop clears while sending
      if (ev.transmitter && (ev.start_gen || ev.stop_gen)) begin
         st_nxt.flags.byte_finished_flag = 1'b0;
      end
      if (rd_dat && !st_r.flags.byte_finished_flag) begin
         st_nxt.flags.receive_not_empty_flag = 1'b0;
      end
      // written data fills register unless a byte is still pending
      if (wr_dat && !st_r.flags.byte_finished_flag) begin
         st_nxt.flags.transmit_empty_flag = 1'b0;
      end
      if (ev.start_gen || ev.stop_gen) begin
         st_nxt.flags.transmit_empty_flag = 1'b0;
      end

      // ----------------------------------------
      // event sets, set wins over clear
      // ----------------------------------------
      if (ev.ack_rcv) begin
         st_nxt.last_ack = 1'b1;
      end else if (ev.nack_rcv) begin
         st_nxt.last_ack = 1'b0;
      end
      if (ev.master_mode && ev.start_gen) begin
         st_nxt.flags.start_sent_flag = 1'b1;
      end
      if (ev.master_mode && st_r.ctrl.ten_bit_mode && ev.addr_first_sent && !ev.nack_rcv) begin
         st_nxt.flags.ten_bit_header_sent_flag = 1'b1;
      end
      if (ev.master_mode && ev.addr_ack && !ev.nack_rcv &&
          (!st_r.ctrl.ten_bit_mode || ev.addr_second)) begin
         st_nxt.flags.address_done_flag = 1'b1;
      end
      if (!ev.master_mode && ev.slave_match && !ev.nack_rcv) begin
         st_nxt.flags.address_done_flag = 1'b1;
      end
      if (!ev.master_mode && stop_det && st_r.last_ack) begin
         st_nxt.flags.stop_seen_flag = 1'b1;
      end
      if (!ev.transmitter && ev.byte_rcvd && !ev.addr_phase && !ev.nack_rcv) begin
         if (!st_r.flags.receive_not_empty_flag || (rd_dat && !st_r.flags.byte_finished_flag)) begin
            st_nxt.rx_data = ev.rx_byte;
            st_nxt.flags.receive_not_empty_flag = 1'b1;
         end else if (!st_r.ctrl.stretch_disable) begin
            // second byte held, data still unread
            st_nxt.flags.byte_finished_flag = 1'b1;
         end
      end
      // engine took the byte, register now empty
      if (ev.transmitter && ev.tx_byte_taken && !ev.addr_phase && !ev.nack_rcv &&
          !st_r.ctrl.checksum_send_request) begin
         st_nxt.flags.transmit_empty_flag = 1'b1;
      end
      if (!st_r.ctrl.stretch_disable && ev.transmitter && ev.tx_due && !ev.nack_rcv &&
          st_r.flags.transmit_empty_flag && !wr_dat && !st_r.ctrl.checksum_send_request) begin
         st_nxt.flags.byte_finished_flag = 1'b1;
      end

      // ----------------------------------------
      // peripheral disable
      // ----------------------------------------
      // disable forces event flags low
      if (!st_nxt.ctrl.enable) begin
         st_nxt.flags = '0;
         st_nxt.status_armed = 1'b0;
         st_nxt.last_ack = 1'b0;
      end
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule : isf_event_flags

// ---- isf_bus_partner.sv ----
`timescale 1ns/1ps
// ----
// far-side bus device: one byte, ack, stop
// ----
module isf_bus_partner (
   input wire logic frame_tgl,
   input wire logic [7:0] frame_byte,
   output logic scl,
   output logic sda
);
   // pull-ups hold both lines high between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   always @(frame_tgl) begin
      #137 sda = 1'b0;
      #400 scl = 1'b0;
      for (int i = 8; i >= 0; i--) begin
         #200 sda = (i == 0) ? 1'b0 : frame_byte[i-1];
         #200 scl = 1'b1;
         #400 scl = 1'b0;
      end
      #200 sda = 1'b0;
      #200 scl = 1'b1;
      #400 sda = 1'b1;
   end
endmodule : isf_bus_partner

// ---- isf_event_flags_chk.sv ----
`timescale 1ns/1ps
module isf_event_flags_chk
   import isf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [1:0] s_axi_bresp,
   input wire isf_ev_t ev,
   input wire isf_flags_t flags,
   input wire isf_ctrl_t ctrl
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);
   logic live;
   assign live = ctrl.enable && !ev.nack_rcv;
   // ----
   // read and write answer steps
   // ----
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence rd_wait;
      s_axi_rvalid && !s_axi_rready;
   endsequence
   chk_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read not answered");
   chk_rd_hold: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   // ----
   // event flags
   // ----
   sequence start_ev;
      live && ev.master_mode && ev.start_gen;
   endsequence
   sequence maddr_ev;
      live && ev.master_mode && ev.addr_ack && (!ctrl.ten_bit_mode || ev.addr_second);
   endsequence
   sequence saddr_ev;
      live && !ev.master_mode && ev.slave_match;
   endsequence
   sequence hdr_ev;
      live && ev.master_mode && ctrl.ten_bit_mode && ev.addr_first_sent;
   endsequence
   // no read in the same cycle: a data read would take the byte instead
   sequence rx_full_ev;
      live && !ctrl.stretch_disable && !ev.transmitter && !ev.addr_phase && ev.byte_rcvd
      && flags.receive_not_empty_flag && !(s_axi_arvalid && s_axi_arready);
   endsequence
   sequence tx_due_ev;
      live && !ctrl.stretch_disable && ev.transmitter && ev.tx_due
      && flags.transmit_empty_flag && !ctrl.checksum_send_request;
   endsequence
   chk_start_set: assert property (start_ev |=> flags.start_sent_flag)
      else $error("start flag not set");
   chk_addr_master: assert property (maddr_ev |=> flags.address_done_flag)
      else $error("master address flag not set");
   chk_addr_slave: assert property (saddr_ev |=> flags.address_done_flag)
      else $error("slave address flag not set");
   chk_ten_hdr: assert property (hdr_ev |=> flags.ten_bit_header_sent_flag)
      else $error("header flag not set");
   chk_rx_fin: assert property (rx_full_ev |=> flags.byte_finished_flag)
      else $error("receive byte finished not set");
   // a data write landing in that cycle counts as new data
   chk_tx_fin: assert property (tx_due_ev |=> flags.byte_finished_flag || $rose(s_axi_bvalid))
      else $error("transmit byte finished not set");
   chk_nack_hold: assert property (ev.nack_rcv && !flags.byte_finished_flag
      |=> !flags.byte_finished_flag)
      else $error("byte finished set on nack");
   chk_off_zero: assert property (!ctrl.enable |-> flags[6:2] == 5'h00)
      else $error("flags set while disabled");
endmodule : isf_event_flags_chk
bind isf_event_flags isf_event_flags_chk i_chk (
   .ref_clk(ref_clk), .reset(reset), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_bresp(s_axi_bresp), .ev(ev), .flags(flags), .ctrl(ctrl)
);

// ---- isf_event_flags_tb_top.sv ----
`timescale 1ns/1ps
`include "isf_defs.svh"
module isf_event_flags_tb_top;
   import isf_pkg::*;
   localparam logic [7:0] a_c1 = `ISF_ADDR_CONTROL_ONE;
   localparam logic [7:0] a_dat = `ISF_ADDR_DATA;
   localparam logic [7:0] a_s1 = `ISF_ADDR_STATUS_ONE;
   localparam logic [7:0] a_s2 = `ISF_ADDR_STATUS_TWO;
   logic ref_clk, reset, awvalid, wvalid, bready, arvalid, rready, frame_tgl;
   logic awready, wready, bvalid, arready, rvalid, scl, sda;
   logic [7:0] awaddr, araddr, frame_byte;
   logic [31:0] wdata, rdata, rnd;
   logic [1:0] bresp, rresp;
   logic [17:0] q[$];
   logic [17:0] n;
   isf_ev_t ev, lv;
   int bad_count, compares, cyc;
   isf_event_flags i_dut (
      .ref_clk(ref_clk), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .scl_in(scl), .sda_in(sda), .ev(ev), .flags(), .ctrl(), .tx_data(), .tx_load()
   );
   isf_bus_partner i_bus (.frame_tgl(frame_tgl), .frame_byte(frame_byte), .scl(scl), .sda(sda));
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic end_sim();
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : end_sim
   // ----
   // bus and event drivers
   // ----
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge ref_clk);
         awvalid <= awvalid && !awready;
         wvalid <= wvalid && !wready;
      end while (!bvalid);
      bready <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m,
                     input logic [1:0] r = `ISF_RESP_OKAY);
      q.push_back({r, m, e});
      @(posedge ref_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge ref_clk);
         arvalid <= arvalid && !arready;
      end while (!rvalid);
      rready <= 1'b0;
   endtask : rd
   task automatic pe(input isf_ev_t p);
      @(posedge ref_clk);
      ev <= p | lv;
      @(posedge ref_clk);
      ev <= lv;
   endtask : pe
   // frame lasts about 85 cycles plus sync
   task automatic frame();
      @(posedge ref_clk);
      frame_byte <= rnd[7:0];
      frame_tgl <= !frame_tgl;
      repeat (120) @(posedge ref_clk);
   endtask : frame
   // ----
   // result watcher
   // ----
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         bad_count++;
         end_sim();
      end
      if (rvalid && rready) begin
         n = q.pop_front();
         compares++;
         if (rresp !== n[17:16] || (rdata[7:0] & n[15:8]) !== (n[7:0] & n[15:8])) begin
            bad_count++;
            $display("BAD read resp/data expected %h/%h seen %h/%h", n[17:16], n[7:0],
                     rresp, rdata[7:0]);
         end
      end
   end
   initial begin
      {reset, awvalid, wvalid, bready, arvalid, rready, frame_tgl} = 7'h40;
      {awaddr, araddr, frame_byte, wdata} = '0;
      ev = '0;
      lv = '0;
      rnd = 32'h0000AAEC;
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      wr(a_c1, 8'h01);
      lv = '{master_mode: 1'b1, default: '0};
      pe('{start_gen: 1'b1, default: '0});
      wr(a_dat, rnd[7:0]);
      rd(a_s1, 8'h01, 8'h3F); // no early clear
      wr(a_dat, rnd[7:0]);
      rd(a_s1, 8'h00, 8'h01); // start cleared
      pe('{addr_ack: 1'b1, default: '0});
      rd(a_s1, 8'h02, 8'h3F); // seven bit
      rd(a_s2, 8'h00, 8'h00);
      rd(a_s1, 8'h00, 8'h02); // address cleared
      wr(a_c1, 8'h09);
      pe('{addr_first_sent: 1'b1, default: '0});
      rd(a_s1, 8'h08, 8'h3F); // header sent
      lv.addr_second = 1'b1;
      pe('{addr_ack: 1'b1, default: '0});
      rd(a_s1, 8'h0A, 8'h3F); // ten bit
      wr(a_c1, 8'h09);
      rd(a_s1, 8'h02, 8'h3F); // header cleared
      rd(a_s2, 8'h00, 8'h00);
      pe('{addr_first_sent: 1'b1, nack_rcv: 1'b1, default: '0});
      rd(a_s1, 8'h00, 8'h0A); // nack blocks
      lv = '{master_mode: 1'b1, transmitter: 1'b1, default: '0};
      pe('{tx_byte_taken: 1'b1, default: '0});
      wr(a_c1, 8'h05);
      pe('{tx_due: 1'b1, default: '0});
      rd(a_s1, 8'h80, 8'h84); // checksum next
      pe('{tx_due: 1'b1, nack_rcv: 1'b1, default: '0});
      rd(a_s1, 8'h80, 8'h84); // checksum still requested, nack too
      wr(a_c1, 8'h01);
      pe('{tx_due: 1'b1, default: '0});
      rd(a_s1, 8'h84, 8'hBF); // byte finished
      pe('{stop_gen: 1'b1, default: '0});
      rd(a_s1, 8'h00, 8'h04); // cleared by stop
      lv = '0;
      for (int s = 0; s < 2; s++) begin
         wr(a_c1, s[0] ? 8'h03 : 8'h01);
         rnd = lfsr(rnd);
         pe('{byte_rcvd: 1'b1, rx_byte: rnd[7:0], default: '0});
         pe('{byte_rcvd: 1'b1, rx_byte: ~rnd[7:0], default: '0});
         rd(a_s1, s[0] ? 8'h40 : 8'h44, 8'h7F); // stretch setting
         rd(a_dat, rnd[7:0], 8'hFF); // data read clears
         rd(a_s1, s[0] ? 8'h00 : 8'h40, 8'h44); // still full only when stretching
         rd(a_dat, 8'h00, 8'h00);
      end
      wr(a_c1, 8'h01);
      pe('{slave_match: 1'b1, default: '0});
      rd(a_s1, 8'h02, 8'h3F); // slave match
      rd(a_s2, 8'h00, 8'h00);
      pe('{ack_rcv: 1'b1, default: '0});
      frame();
      rd(a_s1, 8'h10, 8'h3F); // stop seen
      wr(a_c1, 8'h01);
      rd(a_s1, 8'h00, 8'h10); // stop cleared
      pe('{nack_rcv: 1'b1, default: '0});
      frame();
      rd(a_s1, 8'h00, 8'h10); // no stop after nack
      lv.master_mode = 1'b1;
      pe('{start_gen: 1'b1, default: '0});
      wr(a_c1, 8'h00);
      rd(a_s1, 8'h00, 8'h1F); // disable zeros
      wr(a_c1, 8'h01);
      wr(a_s1, 8'h1F); // status-one write tries to set flags
      rd(a_s1, 8'h00, 8'h3F); // no software set
      rd(8'h40, 8'h00, 8'hFF, `ISF_RESP_SLVERR);
      end_sim();
   end
endmodule : isf_event_flags_tb_top
